//--- acs_pkg.sv
// Package for the converter sequencer: register map, fields, timing
package acs_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [2:0] ACS_OFF_CTRL0 = 3'h0;
  localparam logic [2:0] ACS_OFF_CTRL2 = 3'h1;
  localparam logic [2:0] ACS_OFF_RESH = 3'h2;
  localparam logic [2:0] ACS_OFF_RESL = 3'h3;
  localparam logic [2:0] ACS_OFF_FLAG = 3'h4;
  localparam logic [2:0] ACS_OFF_IEN = 3'h5;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ACS_BIT_ENABLE = 0;
  localparam int ACS_BIT_GO = 1;
  localparam int ACS_CHS_LSB = 2;
  localparam int ACS_ADCS_LSB = 0;
  localparam int ACS_ACQT_LSB = 3;
  localparam int ACS_BIT_FMT = 7;
  localparam int ACS_BIT_DONE = 6;

  // ****************************************************************
  // Values after reset and timing
  // ****************************************************************
  localparam logic [7:0] ACS_RST_BYTE = 8'h00;
  localparam logic [9:0] ACS_RST_RES = 10'h000;
  localparam int ACS_RES_BITS = 10;
  localparam logic [4:0] ACS_CONV_TADS = 5'h0b;
  localparam logic [4:0] ACS_GAP_TADS = 5'h02;
  localparam logic [4:0] ACS_START_TADS = 5'h01;
  localparam int ACS_INSTR_CYCLES = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum {
    ACS_IDLE,
    ACS_WAIT_INSTR,
    ACS_ACQ,
    ACS_CONV,
    ACS_GAP
  } acs_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acs_bus_t;

  typedef struct packed {
    logic converter_enable;
    logic go;
    logic [3:0] channel_select;
    logic result_format_select;
    logic [2:0] acquisition_time_select;
    logic [2:0] conv_clock_select;
    logic conv_done_flag;
    logic conv_irq_enable;
    logic [9:0] result;
    logic [9:0] sar;
    logic [3:0] bit_idx;
    logic [5:0] div_cnt;
    logic [4:0] tad_cnt;
    logic [2:0] instr_cnt;
    logic asleep_off;
    acs_state_t state;
    logic [7:0] rdata;
    logic wake;
    logic timer_clr;
    logic sample;
    logic discharge;
    logic [3:0] chan;
    logic [9:0] dac;
  } acs_regs_t;

endpackage : acs_pkg

//--- acs_sequencer.sv
// Conversion sequencer for a 10-bit successive-approximation converter
import acs_pkg::*;

// Functional notes
// RQ1: Done flag set on every completion
// RQ2: Done flag cleared only by software
// RQ3: Enabled interrupt wakes sleeping device
// RQ4: Clock select picks divider or RC
// RQ5: Software uses RC above 1 MHz only sleeping
// RQ6: Result presented left or right justified
// RQ7: Format one right, zero left justifies
// RQ8: Converter works only while enabled
// RQ9: Go starts conversion or acquisition first
// RQ10: Acquisition code 010 gives 4 periods
// RQ11: Acquisition codes map 0..20 periods
// RQ12: Zero delay starts one instruction later
// RQ13: Software avoids go with enable write
// RQ14: Completion clears go, flags, loads result
// RQ15: Conversion takes eleven bit periods
// RQ16: Capacitor array discharged after each sample
// RQ17: Abort writes partial result, bits extended
// RQ18: Reset clears registers, stops converter
// RQ19: Two periods wait before next acquisition
// RQ20: System keeps clock source during conversion
// RQ21: Software selects RC below 1 MHz
// RQ22: RC clock adds one instruction delay; after a nonzero acquisition code the RC path waits two
// RQ23: Sleep completion without irq powers down
// RQ24: Sleep with non-RC clock aborts conversion
// RQ25: Trigger sets go, clears timer counter
// RQ26: Software waits acquisition with zero delay
// RQ27: Channel field selects inputs, DAC, reference
// RQ28: One bit per period, MSB first
// RQ29: Go reads one until completion or abort
module acs_sequencer #(
  parameter int RES_BITS = ACS_RES_BITS,
  parameter int INSTR_CYCLES = ACS_INSTR_CYCLES
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  // Register port
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // System
  input wire logic SLEEP_I,
  input wire logic RC_TICK_I,
  input wire logic TRIGGER_I,
  output logic WAKE_O,
  output logic TIMER_CLR_O,
  // Analog front end
  input wire logic CMP_I,
  output logic SAMPLE_O,
  output logic DISCHARGE_O,
  output logic [3:0] CHANNEL_O,
  output logic [9:0] DAC_O
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // RQ11: acquisition delay table
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      // RQ10: code 010 gives four periods
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0c;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction : acq_tads

  // RQ4: bit period of divider in clocks, minus one
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0: div_last = 6'h01;
      3'h4: div_last = 6'h03;
      3'h1: div_last = 6'h07;
      3'h5: div_last = 6'h0f;
      3'h2: div_last = 6'h1f;
      3'h6: div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  endfunction : div_last

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == 2'h3);
  endfunction : is_rc

  acs_regs_t q, d;
  logic conv_bit_period;

  // RQ4: bit period strobe from divider or RC clock
  assign conv_bit_period = is_rc(q.conv_clock_select) ? RC_TICK_I :
               (q.div_cnt == div_last(q.conv_clock_select));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [9:0] fill;
    logic done_evt;
    logic abort;
    fill = '0;
    done_evt = 1'b0;
    abort = 1'b0;
    d = q;
    d.wake = 1'b0;
    d.timer_clr = 1'b0;
    d.discharge = 1'b0;
    d.rdata = ACS_RST_BYTE;

    if (q.state == ACS_IDLE || conv_bit_period || is_rc(q.conv_clock_select)) begin
      d.div_cnt = '0;
    end else begin
      d.div_cnt = q.div_cnt + 6'h01;
    end

    // Register writes
    if (WR_I) begin
      case (ADDR_I)
        ACS_OFF_CTRL0: begin
          d.converter_enable = WDATA_I[ACS_BIT_ENABLE];
          d.channel_select = WDATA_I[ACS_CHS_LSB +: 4];
          // RQ29: go set only by one, cleared by zero
          if (WDATA_I[ACS_BIT_GO]) begin
            d.go = 1'b1;
          end else if (q.go) begin
            abort = 1'b1;
          end
        end
        ACS_OFF_CTRL2: begin
          d.result_format_select = WDATA_I[ACS_BIT_FMT];
          d.acquisition_time_select = WDATA_I[ACS_ACQT_LSB +: 3];
          d.conv_clock_select = WDATA_I[ACS_ADCS_LSB +: 3];
        end
        ACS_OFF_FLAG: begin
          // RQ2: only software clears the flag
          d.conv_done_flag = WDATA_I[ACS_BIT_DONE];
        end
        ACS_OFF_IEN: begin
          d.conv_irq_enable = WDATA_I[ACS_BIT_DONE];
        end
        default: begin
        end
      endcase
    end

    // RQ25: trigger sets go and clears timer
    if (TRIGGER_I && q.converter_enable) begin
      d.go = 1'b1;
      d.timer_clr = 1'b1;
    end

    // RQ24: sleep with divided clock aborts and powers down
    if (SLEEP_I && !is_rc(q.conv_clock_select) && q.state != ACS_IDLE
        && q.state != ACS_GAP) begin
      abort = 1'b1;
      d.asleep_off = 1'b1;
    end
    if (!SLEEP_I) begin
      d.asleep_off = 1'b0;
    end

    case (q.state)
      ACS_IDLE: begin
        d.sample = q.converter_enable;
        // RQ8: nothing starts unless enabled
        if (q.go && q.converter_enable && !q.asleep_off) begin
          d.instr_cnt = '0;
          d.tad_cnt = acq_tads(q.acquisition_time_select);
          // RQ9: zero code starts, else acquire first
          d.state = (q.acquisition_time_select == 3'h0) ?
                    ACS_WAIT_INSTR : ACS_ACQ;
        end
      end
      ACS_WAIT_INSTR: begin
        // RQ12: one instruction; RQ22: RC adds another
        d.instr_cnt = q.instr_cnt + 3'h1;
        if (q.instr_cnt == 3'(INSTR_CYCLES *
            (is_rc(q.conv_clock_select) ? 2 : 1) - 1)) begin
          d.sample = 1'b0;
          d.sar = 10'(1 << (RES_BITS - 1));
          d.bit_idx = 4'(RES_BITS - 1);
          d.tad_cnt = ACS_CONV_TADS;
          d.state = ACS_CONV;
        end
      end
      ACS_ACQ: begin
        if (conv_bit_period) begin
          d.tad_cnt = q.tad_cnt - 5'h01;
          if (q.tad_cnt == ACS_START_TADS) begin
            d.instr_cnt = '0;
            d.state = is_rc(q.conv_clock_select) ? ACS_WAIT_INSTR :
                      ACS_CONV;
            d.sample = is_rc(q.conv_clock_select);
            d.sar = 10'(1 << (RES_BITS - 1));
            d.bit_idx = 4'(RES_BITS - 1);
            d.tad_cnt = ACS_CONV_TADS;
          end
        end
      end
      ACS_CONV: begin
        // RQ15: eleven periods; RQ28: MSB first
        if (conv_bit_period) begin
          d.tad_cnt = q.tad_cnt - 5'h01;
          if (q.tad_cnt <= 5'(RES_BITS) && q.tad_cnt != 5'h00) begin
            if (!CMP_I) begin
              d.sar[q.bit_idx] = 1'b0;
            end
            if (q.bit_idx != 4'h0) begin
              d.sar[q.bit_idx - 4'h1] = 1'b1;
              d.bit_idx = q.bit_idx - 4'h1;
            end
          end
          if (q.tad_cnt == ACS_START_TADS) begin
            done_evt = 1'b1;
          end
        end
      end
      ACS_GAP: begin
        // RQ19: two periods before next acquisition
        if (conv_bit_period) begin
          d.tad_cnt = q.tad_cnt - 5'h01;
          if (q.tad_cnt == ACS_START_TADS) begin
            d.state = ACS_IDLE;
            d.sample = q.converter_enable;
          end
        end
      end
      default: begin
        d.state = ACS_IDLE;
      end
    endcase

    // RQ14: completion clears go, flags, loads result
    if (done_evt) begin
      d.go = 1'b0;
      // RQ1: flag set regardless of enable
      d.conv_done_flag = 1'b1;
      d.result = d.sar;
      d.state = ACS_GAP;
      d.tad_cnt = ACS_GAP_TADS;
      // RQ16: discharge after every sample
      d.discharge = 1'b1;
      // RQ3: wake on enabled interrupt in sleep
      d.wake = SLEEP_I && q.conv_irq_enable;
      // RQ23: no interrupt in sleep powers down
      d.asleep_off = SLEEP_I && !q.conv_irq_enable;
    end else if (abort && q.state != ACS_IDLE && q.state != ACS_GAP) begin
      // RQ17: unconverted bits copy last converted bit
      d.go = 1'b0;
      if (q.state == ACS_CONV && q.bit_idx != 4'(RES_BITS - 1)) begin
        for (int i = 0; i < RES_BITS; i++) begin
          fill[i] = (4'(i) > q.bit_idx) ? q.sar[i] : q.sar[q.bit_idx + 4'h1];
        end
        d.result = fill;
      end
      d.state = ACS_GAP;
      d.tad_cnt = ACS_GAP_TADS;
      d.discharge = 1'b1;
      d.sample = 1'b0;
    end else if (abort) begin
      d.go = 1'b0;
    end

    // Converter off cancels any activity
    if (!d.converter_enable) begin
      d.state = ACS_IDLE;
      d.go = 1'b0;
      d.sample = 1'b0;
    end

    // RQ2: set wins over a same-cycle software clear
    if (done_evt) begin
      d.conv_done_flag = 1'b1;
    end

    // RQ27: channel code drives the mux directly
    d.chan = q.channel_select;
    // Trial word leaves with the SAR itself, so the comparator settles
    // within the shortest bit period of two clocks
    d.dac = d.sar;

    if (RD_I) begin
      case (ADDR_I)
        ACS_OFF_CTRL0: d.rdata = {2'h0, q.channel_select, q.go,
                                  q.converter_enable};
        ACS_OFF_CTRL2: d.rdata = {q.result_format_select, 1'b0,
                                  q.acquisition_time_select,
                                  q.conv_clock_select};
        // RQ6: RQ7: justified presentation
        ACS_OFF_RESH: d.rdata = q.result_format_select ?
                                {6'h00, q.result[9:8]} : q.result[9:2];
        ACS_OFF_RESL: d.rdata = q.result_format_select ?
                                q.result[7:0] : {q.result[1:0], 6'h00};
        ACS_OFF_FLAG: d.rdata = {1'b0, q.conv_done_flag, 6'h00};
        ACS_OFF_IEN: d.rdata = {1'b0, q.conv_irq_enable, 6'h00};
        default: d.rdata = ACS_RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // RQ18: reset returns all to defaults, converter off
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '0;
      q.state <= ACS_IDLE;
    end else if (CE_I) begin
      q <= d;
    end
  end

  assign RDATA_O = q.rdata;
  assign WAKE_O = q.wake;
  assign TIMER_CLR_O = q.timer_clr;
  assign SAMPLE_O = q.sample;
  assign DISCHARGE_O = q.discharge;
  assign CHANNEL_O = q.chan;
  assign DAC_O = q.dac;

endmodule : acs_sequencer

//--- acs_checker.sv
// Port assertions for the converter sequencer
module acs_checker
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Inputs watched
  input wire logic TRIGGER_I,
  input wire logic SLEEP_I,
  // Outputs watched
  input wire logic [7:0] RDATA_O,
  input wire logic WAKE_O,
  input wire logic TIMER_CLR_O,
  input wire logic SAMPLE_O,
  input wire logic DISCHARGE_O,
  input wire logic [9:0] DAC_O
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  AST_RST_OUT: assert property (
    $rose(ARST_N_I) |-> !WAKE_O && !SAMPLE_O && !DISCHARGE_O
      && DAC_O == 10'h000 && RDATA_O == 8'h00)
    else $error("outputs not idle after reset");
  AST_TRIG_CLR: assert property (
    TIMER_CLR_O |-> $past(TRIGGER_I))
    else $error("timer clear without trigger");
  AST_DISCH_PULSE: assert property (
    DISCHARGE_O |=> !DISCHARGE_O)
    else $error("discharge longer than one cycle");
  AST_DISCH_NO_SAMPLE: assert property (
    DISCHARGE_O |-> !SAMPLE_O)
    else $error("discharge while sampling");
  AST_GAP: assert property (
    DISCHARGE_O |=> !SAMPLE_O [*3])
    else $error("sampling resumed too early");
  AST_WAKE: assert property (
    WAKE_O |-> $past(SLEEP_I) && (DISCHARGE_O || $past(DISCHARGE_O)))
    else $error("wake without completion in sleep");
  AST_MSB_FIRST: assert property (
    $past(DAC_O) == 10'h000 && DAC_O != 10'h000 |-> DAC_O == 10'h200)
    else $error("first trial word is not the top bit");
  // Shortest period is two clocks, so eleven periods exceed eight clocks
  AST_CONV_LEN: assert property (
    $past(DAC_O) == 10'h000 && DAC_O == 10'h200 |=> !DISCHARGE_O [*8])
    else $error("conversion ended too soon");

  COV_DISCH: cover property (DISCHARGE_O);
  COV_WAKE: cover property (WAKE_O);
  COV_TRIG: cover property (TIMER_CLR_O);
endmodule : acs_checker

bind acs_sequencer acs_checker acs_checker_inst (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .TRIGGER_I(TRIGGER_I),
  .SLEEP_I(SLEEP_I), .RDATA_O(RDATA_O), .WAKE_O(WAKE_O),
  .TIMER_CLR_O(TIMER_CLR_O), .SAMPLE_O(SAMPLE_O),
  .DISCHARGE_O(DISCHARGE_O), .DAC_O(DAC_O)
);

//--- tb_top.sv
// Self-checking bench for the converter sequencer
`define CHK(nm, e, g) check(nm, (g) === (e), 16'(e), 16'(g))
module tb_top
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus and wiring
  // ****************************************************************
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, trig = 0, sleep = 0;
  logic cmp = 0, rc_tick = 0, wake, tclr, sample, disch;
  logic [2:0] addr = 0, rc_cnt = 0;
  logic [7:0] wdata = 0, rdata;
  logic [3:0] chan;
  logic [9:0] dac, tgt = 0;
  int errors = 0, n_compared = 0;
  int acq_tbl[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  always #12.5 clk = ~clk;
  // Comparator keeps a trial bit while the trial word is not above input
  always @(posedge clk) begin
    cmp <= (dac <= tgt);
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
  end

  acs_sequencer acs_sequencer_inst (
    .CLK_I(clk), .ARST_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SLEEP_I(sleep), .RC_TICK_I(rc_tick), .TRIGGER_I(trig),
    .WAKE_O(wake), .TIMER_CLR_O(tclr), .CMP_I(cmp), .SAMPLE_O(sample),
    .DISCHARGE_O(disch), .CHANNEL_O(chan), .DAC_O(dac)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic check(input string nm, input logic ok,
                       input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e,
                        input string nm);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(nm, e, d);
  endtask : chk_rd

  // Bounded wait for the end-of-conversion discharge pulse
  task automatic wait_disch(output int cyc);
    cyc = 0;
    while (disch !== 1'b1 && cyc < 5000) begin
      @(posedge clk);
      #1 cyc++;
    end
    if (cyc >= 5000) begin
      errors++;
      results();
    end
  endtask : wait_disch

  // Clock code i, acquisition code i, format i[0]
  task automatic conv(input int i);
    int cyc, p, lo;
    logic [3:0] ch;
    ch = 4'(15 - i);
    p = (i % 4 == 3) ? 5 : 1 << (1 + 2 * (i % 4) + i / 4);
    lo = (acq_tbl[i] + 11) * p;
    tgt = 10'h2a5 ^ 10'(i * 97);
    wr_reg(ACS_OFF_CTRL2, {i[0], 1'b0, 3'(i), 3'(i)});
    // this write sets channel ch together with go; enable is already on
    wr_reg(ACS_OFF_CTRL0, {2'b00, ch, 2'b11});
    wait_disch(cyc);
    `CHK("duration", 1'b1, cyc >= lo - p && cyc <= lo + 2 * p + 12);
    `CHK("channel", ch, chan);
    repeat (3 * p + 2) @(posedge clk);
    `CHK("sample", 1'b1, sample);
    chk_rd(ACS_OFF_CTRL0, {2'b00, ch, 2'b01}, "go_clear");
    chk_rd(ACS_OFF_FLAG, 8'h40, "flag");
    chk_rd(ACS_OFF_RESH, i[0] ? {6'h00, tgt[9:8]} : tgt[9:2], "resh");
    chk_rd(ACS_OFF_RESL, i[0] ? tgt[7:0] : {tgt[1:0], 6'h00}, "resl");
    chk_rd(ACS_OFF_FLAG, 8'h40, "flag_hold");
    wr_reg(ACS_OFF_FLAG, 8'h00);
    chk_rd(ACS_OFF_FLAG, 8'h00, "flag_clear");
  endtask : conv

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [7:0] h, l;
    logic [9:0] f;
    logic seen;
    int cyc;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      chk_rd(3'(a), 8'h00, "reset");
    wr_reg(ACS_OFF_CTRL0, 8'h02);
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    chk_rd(ACS_OFF_CTRL0, 8'h00, "go_disabled");
    $display("test reset and disabled done");
    wr_reg(ACS_OFF_CTRL0, 8'h01);
    for (int i = 0; i < 8; i++)
      conv(i);
    $display("test clock and acquisition codes done");
    // internal clock only for sleep runs
    wr_reg(ACS_OFF_CTRL2, 8'h03);
    for (int j = 0; j < 2; j++) begin
      wr_reg(ACS_OFF_IEN, j ? 8'h40 : 8'h00);
      @(posedge clk) sleep <= 1'b1;
      wr_reg(ACS_OFF_CTRL0, 8'h03);
      seen = 1'b0;
      repeat (400) begin
        @(posedge clk);
        #1 seen = seen | (wake === 1'b1);
      end
      `CHK("wake", 1'(j), seen);
      chk_rd(ACS_OFF_CTRL0, 8'h01, "sleep_done");
      @(posedge clk) sleep <= 1'b0;
      wr_reg(ACS_OFF_FLAG, 8'h00);
    end
    $display("test sleep with internal clock done");
    wr_reg(ACS_OFF_CTRL2, 8'h01);
    wr_reg(ACS_OFF_CTRL0, 8'h03);
    repeat (40) @(posedge clk);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    chk_rd(ACS_OFF_CTRL0, 8'h01, "sleep_abort");
    @(posedge clk) sleep <= 1'b0;
    $display("test sleep abort done");
    wr_reg(ACS_OFF_CTRL2, 8'h86);
    tgt = 10'h2a5;
    wr_reg(ACS_OFF_CTRL0, 8'h03);
    repeat (300) @(posedge clk);
    wr_reg(ACS_OFF_CTRL0, 8'h01);
    repeat (4) @(posedge clk);
    rd_reg(ACS_OFF_RESH, h);
    rd_reg(ACS_OFF_RESL, l);
    seen = 1'b0;
    // Any abort after the first decided bit is legal; the fill pattern must match one of them
    for (int k = 1; k <= 10; k++) begin
      f = tgt;
      for (int b = 0; b < 10 - k; b++)
        f[b] = tgt[10 - k];
      seen = seen | ({h[1:0], l} === f);
    end
    `CHK("partial", 1'b1, seen);
    chk_rd(ACS_OFF_CTRL0, 8'h01, "abort_go");
    $display("test abort done");
    wr_reg(ACS_OFF_CTRL2, 8'h00);
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    #1 `CHK("timer_clear", 1'b1, tclr);
    chk_rd(ACS_OFF_CTRL0, 8'h03, "trigger_go");
    wait_disch(cyc);
    $display("test trigger done");
    results();
  end
endmodule : tb_top
